/* verilog/fmop_top.sv */
/*
  Output processing of a flow meter: damping, cut-off, limit switching,
  analog scaling, totaliser, preset counter, pulse output and simulation.
  Assumes all inputs are synchronous to CLK_SYS and SAMPLE_STB marks a new
  measurement; the persistent store is external and acts on BACKUP_STB.
*/
`timescale 1ns/1ps
// Behaviour
// - First output has five selectable functions
// - Second output has nine selectable functions
// - Switch outputs compare against limits, hysteresis/window
// - Hysteresis needs release below switch threshold
// - Moving switch threshold keeps previous gap
// - Window limits use fixed quarter-percent hysteresis
// - Analog current spans 4 to 20 mA
// - Start and end points set linear mapping
// - Analog span at least twenty percent
// - Error sends current high, low, or normal
// - Totaliser accumulates, keeps previous value, elapsed time
// - Totaliser and timer saved every ten minutes
// - Totaliser clears manually, timed, external, overflow
// - Only one output may monitor consumption
// - Pulse emitted per configured quantity step
// - Preset switch latches when quantity reached
// - Time window selects unlimited or limited period
// - Expired unswitched window restarts preset count
// - Damping time constant applies to all outputs
// - Flow below cut-off counts as zero
// - Simulation freezes totaliser, runs simulated one
// - Simulation suppresses errors, real totaliser unchanged
module fmop_top #(
  parameter int VW = fmop_pkg::FMOP_VW,
  parameter longint BACKUP_CYC = fmop_pkg::FMOP_BACKUP_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic SAMPLE_STB,
  input wire logic [15:0] FLOW_IN,
  input wire logic [15:0] TEMP_IN,
  input wire logic SENSOR_ERROR,
  input wire logic [2:0] FIRST_OUTPUT_FUNC,
  input wire logic [3:0] SECOND_OUTPUT_FUNC,
  input wire logic WINDOW_MODE_1,
  input wire logic WINDOW_MODE_2,
  input wire logic [15:0] SWITCH_THRESHOLD,
  input wire logic SWITCH_THRESHOLD_WE,
  input wire logic [15:0] RELEASE_THRESHOLD,
  input wire logic RELEASE_THRESHOLD_WE,
  input wire logic [15:0] WINDOW_UPPER_LIMIT,
  input wire logic [15:0] WINDOW_LOWER_LIMIT,
  input wire logic [15:0] ANALOG_START_POINT,
  input wire logic [15:0] ANALOG_END_POINT,
  input wire logic [1:0] FAILURE_LEVEL_SELECT,
  input wire logic [31:0] PULSE_QUANTITY_SETTING,
  input wire logic [31:0] COUNTER_TIME_WINDOW,
  input wire logic [3:0] DAMPING_TIME,
  input wire logic [15:0] LOW_FLOW_CUTOFF,
  input wire logic MANUAL_RESET,
  input wire logic EXTERNAL_RESET_INPUT,
  input wire logic SIM_ACTIVE,
  input wire logic [15:0] SIM_FLOW,
  input wire logic RESTORE_STB,
  input wire logic [31:0] RESTORE_TOTAL,
  input wire logic [31:0] RESTORE_ELAPSED,
  output logic FIRST_OUTPUT,
  output logic FIRST_OUTPUT_OE,
  output logic SECOND_OUTPUT,
  output logic SECOND_OUTPUT_OE,
  output logic [15:0] ANALOG_CURRENT,
  output logic [15:0] DISPLAY_VALUE,
  output logic [31:0] TOTAL_VALUE,
  output logic [31:0] PREVIOUS_TOTAL,
  output logic [31:0] ELAPSED_SAMPLES,
  output logic BACKUP_STB,
  output logic [31:0] BACKUP_TOTAL,
  output logic [31:0] BACKUP_ELAPSED,
  output logic ERROR_FLAG,
  output logic CONFIG_REJECT
);

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic [15:0] flow_src;
  logic [15:0] flow_cut;
  logic [23:0] damp_acc_r;
  logic [23:0] damp_acc_nxt;
  logic [15:0] flow_damp;
  logic [23:0] tdamp_acc_r;
  logic [23:0] tdamp_acc_nxt;
  logic [15:0] temp_damp;

  assign flow_src = SIM_ACTIVE ? SIM_FLOW : FLOW_IN;
  assign flow_cut = (flow_src < LOW_FLOW_CUTOFF) ? 16'h0000 : flow_src;
  // First-order filter; the shift sets the 63% time in samples (2^DAMPING_TIME).
  assign damp_acc_nxt = damp_acc_r - (damp_acc_r >> DAMPING_TIME)
    + (24'({flow_cut, 8'h00}) >> DAMPING_TIME);
  assign tdamp_acc_nxt = tdamp_acc_r - (tdamp_acc_r >> DAMPING_TIME)
    + (24'({TEMP_IN, 8'h00}) >> DAMPING_TIME);
  assign flow_damp = damp_acc_r[23:8];
  assign temp_damp = tdamp_acc_r[23:8];

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      damp_acc_r <= 24'h000000;
      tdamp_acc_r <= 24'h000000;
    end
    else if (SAMPLE_STB)
    begin
      damp_acc_r <= damp_acc_nxt;
      tdamp_acc_r <= tdamp_acc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Thresholds
  // ----------------------------------------------------------------
  logic [15:0] sp_r;
  logic [15:0] rp_r;
  logic [15:0] gap;
  logic [16:0] rp_moved;
  logic rp_ok;

  assign gap = sp_r - rp_r;
  assign rp_moved = {1'b0, SWITCH_THRESHOLD} - {1'b0, gap};
  assign rp_ok = RELEASE_THRESHOLD < sp_r;

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      sp_r <= 16'h0001;
      rp_r <= 16'h0000;
    end
    else if (SWITCH_THRESHOLD_WE && !rp_moved[16] && SWITCH_THRESHOLD != 16'h0000)
    begin
      sp_r <= SWITCH_THRESHOLD;
      rp_r <= rp_moved[15:0];
    end
    else if (RELEASE_THRESHOLD_WE && rp_ok)
      rp_r <= RELEASE_THRESHOLD;
  end

  function automatic logic cmp_next(input logic cur, input logic win, input logic [15:0] v,
    input logic [15:0] sp, input logic [15:0] rp, input logic [15:0] hi, input logic [15:0] lo);
    logic inside_on;
    logic inside_off;
    inside_on = (v >= lo + fmop_pkg::FMOP_WIN_HYST) && (v + fmop_pkg::FMOP_WIN_HYST <= hi);
    inside_off = (v + fmop_pkg::FMOP_WIN_HYST < lo) || (v > hi + fmop_pkg::FMOP_WIN_HYST);
    if (win)
      cmp_next = inside_on ? 1'b1 : (inside_off ? 1'b0 : cur);
    else
      cmp_next = (v > sp) ? 1'b1 : ((v < rp) ? 1'b0 : cur);
  endfunction

  // ----------------------------------------------------------------
  // Totaliser, preset counter and pulses
  // ----------------------------------------------------------------
  logic [31:0] tot_r;
  logic [31:0] sim_tot_r;
  logic [31:0] prev_r;
  logic [31:0] elapsed_r;
  logic [31:0] preset_r;
  logic [31:0] pulse_acc_r;
  logic preset_hit_r;
  logic pulse_r;
  logic sim_d_r;
  logic [63:0] backup_cnt_r;
  logic [31:0] tot_sum;
  logic overflow;
  logic ext_sel;
  logic ext_rst;
  logic timed_rst;
  logic clear_all;
  logic [31:0] preset_sum;
  logic [31:0] pulse_sum;
  logic pulse_hit;
  logic pulse_use;
  logic preset_use;

  assign ext_sel = SECOND_OUTPUT_FUNC == fmop_pkg::F2_EXTRST;
  assign ext_rst = ext_sel && EXTERNAL_RESET_INPUT;
  assign tot_sum = tot_r + 32'(flow_damp);
  assign overflow = SAMPLE_STB && !SIM_ACTIVE && tot_sum > fmop_pkg::FMOP_TOT_MAX;
  assign timed_rst = COUNTER_TIME_WINDOW != 32'h00000000 && elapsed_r >= COUNTER_TIME_WINDOW;
  assign clear_all = MANUAL_RESET || ext_rst || overflow || (timed_rst && !preset_hit_r);
  assign preset_sum = preset_r + 32'(flow_damp);
  assign pulse_sum = pulse_acc_r + 32'(flow_damp);
  assign pulse_hit = PULSE_QUANTITY_SETTING != 32'h00000000
    && pulse_sum >= PULSE_QUANTITY_SETTING;
  assign pulse_use = FIRST_OUTPUT_FUNC == fmop_pkg::F1_PULSE
    || SECOND_OUTPUT_FUNC == fmop_pkg::F2_PULSE;
  assign preset_use = FIRST_OUTPUT_FUNC == fmop_pkg::F1_PRESET
    || SECOND_OUTPUT_FUNC == fmop_pkg::F2_PRESET;

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      tot_r <= 32'h00000000;
      prev_r <= 32'h00000000;
      elapsed_r <= 32'h00000000;
    end
    else if (RESTORE_STB)
    begin
      tot_r <= RESTORE_TOTAL;
      elapsed_r <= RESTORE_ELAPSED;
    end
    else if (!SIM_ACTIVE && (MANUAL_RESET || ext_rst || overflow || timed_rst))
    begin
      prev_r <= tot_r;
      tot_r <= 32'h00000000;
      elapsed_r <= 32'h00000000;
    end
    else if (SAMPLE_STB && !SIM_ACTIVE)
    begin
      tot_r <= tot_sum;
      elapsed_r <= elapsed_r + 32'h00000001;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      sim_tot_r <= 32'h00000000;
      sim_d_r <= 1'b0;
    end
    else
    begin
      sim_d_r <= SIM_ACTIVE;
      if (SIM_ACTIVE && !sim_d_r)
        sim_tot_r <= 32'h00000000;
      else if (SIM_ACTIVE && SAMPLE_STB)
        sim_tot_r <= sim_tot_r + 32'(flow_damp);
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      preset_r <= 32'h00000000;
      preset_hit_r <= 1'b0;
      pulse_acc_r <= 32'h00000000;
      pulse_r <= 1'b0;
    end
    else
    begin
      pulse_r <= SAMPLE_STB && pulse_use && pulse_hit;
      if (MANUAL_RESET || ext_rst || overflow)
      begin
        preset_r <= 32'h00000000;
        preset_hit_r <= 1'b0;
      end
      else if (timed_rst && !preset_hit_r)
        preset_r <= 32'h00000000;
      else if (SAMPLE_STB && preset_use)
      begin
        preset_r <= preset_sum;
        if (preset_sum >= PULSE_QUANTITY_SETTING)
          preset_hit_r <= 1'b1;
      end
      if (SAMPLE_STB && pulse_use)
        pulse_acc_r <= pulse_hit ? pulse_sum - PULSE_QUANTITY_SETTING : pulse_sum;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      backup_cnt_r <= 64'h0000000000000000;
      BACKUP_STB <= 1'b0;
      BACKUP_TOTAL <= 32'h00000000;
      BACKUP_ELAPSED <= 32'h00000000;
    end
    else
    begin
      BACKUP_STB <= backup_cnt_r == 64'(BACKUP_CYC - 1);
      backup_cnt_r <= (backup_cnt_r == 64'(BACKUP_CYC - 1)) ? 64'h0 : backup_cnt_r + 64'h1;
      if (backup_cnt_r == 64'(BACKUP_CYC - 1))
      begin
        BACKUP_TOTAL <= tot_r;
        BACKUP_ELAPSED <= elapsed_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  logic sw1_flow_r;
  logic sw1_temp_r;
  logic sw2_flow_r;
  logic sw2_temp_r;
  logic cfg_bad;
  logic span_ok;
  logic err_vis;
  logic [15:0] a_val;
  logic [15:0] a_span;
  logic [15:0] a_off;
  logic [31:0] a_prod;
  logic [15:0] a_norm;
  logic [15:0] a_cur;
  logic first_output_nxt;
  logic second_output_nxt;

  // A pulse function counts as monitoring, so both outputs may not hold one together.
  assign cfg_bad = (FIRST_OUTPUT_FUNC == fmop_pkg::F1_PRESET
    || FIRST_OUTPUT_FUNC == fmop_pkg::F1_PULSE)
    && (SECOND_OUTPUT_FUNC == fmop_pkg::F2_PRESET || SECOND_OUTPUT_FUNC == fmop_pkg::F2_QTY
    || SECOND_OUTPUT_FUNC == fmop_pkg::F2_PULSE);
  assign span_ok = ANALOG_END_POINT >= ANALOG_START_POINT
    && ANALOG_END_POINT - ANALOG_START_POINT >= fmop_pkg::FMOP_MIN_SPAN;
  assign err_vis = SENSOR_ERROR && !SIM_ACTIVE;
  assign a_val = (SECOND_OUTPUT_FUNC == fmop_pkg::F2_ATEMP) ? temp_damp : flow_damp;
  assign a_span = ANALOG_END_POINT - ANALOG_START_POINT;
  assign a_off = a_val <= ANALOG_START_POINT ? 16'h0000
    : (a_val >= ANALOG_END_POINT ? a_span : a_val - ANALOG_START_POINT);
  // A refused span holds the normal current (a_norm) at 4 mA rather than scaling by a meaningless divisor.
  assign a_prod = span_ok ? (32'(a_off) * 32'(fmop_pkg::FMOP_I_SPAN)) / 32'(a_span)
    : 32'h00000000;
  assign a_norm = fmop_pkg::FMOP_I_4MA + a_prod[15:0];
  assign a_cur = !err_vis ? a_norm
    : (FAILURE_LEVEL_SELECT == fmop_pkg::FAIL_HIGH ? fmop_pkg::FMOP_I_HI_ERR
    : (FAILURE_LEVEL_SELECT == fmop_pkg::FAIL_LOW ? fmop_pkg::FMOP_I_LO_ERR : a_norm));

  always_comb
  begin
    unique case (fmop_pkg::fmop_f1_t'(FIRST_OUTPUT_FUNC))
      fmop_pkg::F1_FLOW: first_output_nxt = sw1_flow_r;
      fmop_pkg::F1_TEMP: first_output_nxt = sw1_temp_r;
      fmop_pkg::F1_PRESET: first_output_nxt = preset_hit_r && !cfg_bad;
      fmop_pkg::F1_PULSE: first_output_nxt = pulse_r && !cfg_bad;
      default: first_output_nxt = 1'b0;
    endcase
    unique case (fmop_pkg::fmop_f2_t'(SECOND_OUTPUT_FUNC))
      fmop_pkg::F2_FLOW: second_output_nxt = sw2_flow_r;
      fmop_pkg::F2_TEMP: second_output_nxt = sw2_temp_r;
      fmop_pkg::F2_PRESET: second_output_nxt = preset_hit_r && !cfg_bad;
      fmop_pkg::F2_QTY: second_output_nxt = preset_hit_r && !cfg_bad;
      fmop_pkg::F2_PULSE: second_output_nxt = pulse_r && !cfg_bad;
      default: second_output_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      sw1_flow_r <= 1'b0;
      sw1_temp_r <= 1'b0;
      sw2_flow_r <= 1'b0;
      sw2_temp_r <= 1'b0;
    end
    else if (SAMPLE_STB)
    begin
      // Comparator state survives threshold edits, so unchanged functions do not glitch.
      sw1_flow_r <= cmp_next(sw1_flow_r, WINDOW_MODE_1, flow_damp, sp_r, rp_r,
        WINDOW_UPPER_LIMIT, WINDOW_LOWER_LIMIT);
      sw1_temp_r <= cmp_next(sw1_temp_r, WINDOW_MODE_1, temp_damp, sp_r, rp_r,
        WINDOW_UPPER_LIMIT, WINDOW_LOWER_LIMIT);
      sw2_flow_r <= cmp_next(sw2_flow_r, WINDOW_MODE_2, flow_damp, sp_r, rp_r,
        WINDOW_UPPER_LIMIT, WINDOW_LOWER_LIMIT);
      sw2_temp_r <= cmp_next(sw2_temp_r, WINDOW_MODE_2, temp_damp, sp_r, rp_r,
        WINDOW_UPPER_LIMIT, WINDOW_LOWER_LIMIT);
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      FIRST_OUTPUT <= 1'b0;
      FIRST_OUTPUT_OE <= 1'b0;
      SECOND_OUTPUT <= 1'b0;
      SECOND_OUTPUT_OE <= 1'b0;
      ANALOG_CURRENT <= 16'h0000;
      DISPLAY_VALUE <= 16'h0000;
      TOTAL_VALUE <= 32'h00000000;
      PREVIOUS_TOTAL <= 32'h00000000;
      ELAPSED_SAMPLES <= 32'h00000000;
      ERROR_FLAG <= 1'b0;
      CONFIG_REJECT <= 1'b0;
    end
    else
    begin
      FIRST_OUTPUT <= first_output_nxt;
      FIRST_OUTPUT_OE <= FIRST_OUTPUT_FUNC < 3'h4;
      SECOND_OUTPUT <= second_output_nxt;
      SECOND_OUTPUT_OE <= SECOND_OUTPUT_FUNC != 4'h6 && SECOND_OUTPUT_FUNC != 4'h7
        && SECOND_OUTPUT_FUNC != 4'h4 && SECOND_OUTPUT_FUNC != 4'h5 && SECOND_OUTPUT_FUNC < 4'h9;
      ANALOG_CURRENT <= (SECOND_OUTPUT_FUNC == 4'h4 || SECOND_OUTPUT_FUNC == 4'h5)
        ? a_cur : 16'h0000;
      DISPLAY_VALUE <= flow_damp;
      TOTAL_VALUE <= SIM_ACTIVE ? sim_tot_r : tot_r;
      PREVIOUS_TOTAL <= prev_r;
      ELAPSED_SAMPLES <= elapsed_r;
      ERROR_FLAG <= err_vis;
      CONFIG_REJECT <= cfg_bad || !span_ok;
    end
  end

endmodule

/* pkg/fmop_pkg.sv */
/*
  Shared constants for the flow meter output processing block.
  Assumes values are unsigned fixed-point counts of full scale, FMOP_FS = 100 percent.
*/
package fmop_pkg;
  localparam int FMOP_VW = 16;
  localparam logic [15:0] FMOP_FS = 16'h2710;
  localparam logic [15:0] FMOP_WIN_HYST = 16'h0019;
  localparam logic [15:0] FMOP_MIN_SPAN = 16'h07d0;
  localparam logic [15:0] FMOP_I_4MA = 16'h0fa0;
  localparam logic [15:0] FMOP_I_SPAN = 16'h3e80;
  localparam logic [15:0] FMOP_I_HI_ERR = 16'h53fc;
  localparam logic [15:0] FMOP_I_LO_ERR = 16'h0dac;
  localparam int FMOP_CLK_MHZ = 200;
  localparam int FMOP_BACKUP_MIN = 10;
  localparam longint FMOP_BACKUP_CYC = longint'(FMOP_BACKUP_MIN) * 60 * FMOP_CLK_MHZ * 1000000;
  localparam logic [31:0] FMOP_TOT_MAX = 32'h3b9ac9ff;
  typedef enum logic [2:0] {F1_FLOW, F1_TEMP, F1_PRESET, F1_PULSE, F1_OFF} fmop_f1_t;
  typedef enum logic [3:0] {F2_FLOW, F2_TEMP, F2_PRESET, F2_QTY, F2_AFLOW, F2_ATEMP,
    F2_EXTRST, F2_OFF, F2_PULSE} fmop_f2_t;
  typedef enum logic [1:0] {FAIL_HIGH, FAIL_LOW, FAIL_FOLLOW} fmop_fail_t;
endpackage

/* bench/fmop_chk.sv */
/*
  Port checker for the flow meter output processing block.
  Assumes it is bound into fmop_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module fmop_chk (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic SAMPLE_STB,
  input wire logic SENSOR_ERROR,
  input wire logic SIM_ACTIVE,
  input wire logic [2:0] FIRST_OUTPUT_FUNC,
  input wire logic [3:0] SECOND_OUTPUT_FUNC,
  input wire logic [1:0] FAILURE_LEVEL_SELECT,
  input wire logic FIRST_OUTPUT,
  input wire logic FIRST_OUTPUT_OE,
  input wire logic SECOND_OUTPUT,
  input wire logic SECOND_OUTPUT_OE,
  input wire logic [15:0] ANALOG_CURRENT,
  input wire logic [31:0] PREVIOUS_TOTAL,
  input wire logic BACKUP_STB,
  input wire logic ERROR_FLAG,
  input wire logic CONFIG_REJECT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // The error level is only checked while CONFIG_REJECT reports no span or double-monitoring fault.
  wire err_hi = SENSOR_ERROR && !SIM_ACTIVE && !CONFIG_REJECT &&
    FAILURE_LEVEL_SELECT == 2'h0 && SECOND_OUTPUT_FUNC == 4'h4;
  a_first_off_hiz: assert property ((FIRST_OUTPUT_FUNC >= 3'h4) [*3] |=> !FIRST_OUTPUT_OE)
    else $error("first output driven while off");
  a_second_off_hiz: assert property ((SECOND_OUTPUT_FUNC == 4'h7) [*3] |=> !SECOND_OUTPUT_OE)
    else $error("second output driven while off");
  a_fail_high_lvl: assert property ((err_hi && SAMPLE_STB) ##1 err_hi [*3] |=>
    ANALOG_CURRENT == fmop_pkg::FMOP_I_HI_ERR)
    else $error("error current not at high level");
  // Back-to-back strobes may legally give back-to-back pulses.
  a_pulse_one_cyc: assert property ((FIRST_OUTPUT_FUNC == 3'h3 && FIRST_OUTPUT) |=>
    !FIRST_OUTPUT || $past(SAMPLE_STB, 2))
    else $error("pulse longer than one cycle");
  a_dual_mon_rej: assert property ((FIRST_OUTPUT_FUNC == 3'h3 && SECOND_OUTPUT_FUNC == 4'h8) [*3]
    |=> CONFIG_REJECT && !FIRST_OUTPUT && !SECOND_OUTPUT)
    else $error("double consumption monitoring not refused");
  a_sim_err_mask: assert property (SIM_ACTIVE [*3] |=> !ERROR_FLAG)
    else $error("error shown during simulation");
  a_sim_prev_kept: assert property (SIM_ACTIVE [*3] |=> $stable(PREVIOUS_TOTAL))
    else $error("stored total changed during simulation");
  a_error_seen: assert property ((SENSOR_ERROR && !SIM_ACTIVE) [*5] |=> ERROR_FLAG)
    else $error("process error not flagged");
  a_backup_single: assert property (BACKUP_STB |=> !BACKUP_STB [*8])
    else $error("backup strobe repeated too soon");
endmodule
bind fmop_top fmop_chk i_chk (.*);

/* bench/fmop_ctrl_model.sv */
/*
  Control system model that reads the two switching lines.
  Assumes its inputs are pulled down, so an output at high impedance reads low.
*/
`timescale 1ns/1ps
module fmop_ctrl_model (
  input wire logic q1,
  input wire logic oe1,
  input wire logic q2,
  input wire logic oe2,
  output logic line1,
  output logic line2,
  output int pulses
);
  assign line1 = oe1 ? q1 : 1'b0;
  assign line2 = oe2 ? q2 : 1'b0;
  initial pulses = 0;
  always @(posedge line1)
    pulses = pulses + 1;
endmodule

/* bench/flow_meter_output_processing_tb.sv */
/*
  Self-checking bench for the flow meter output processing block.
  Assumes a 200 MHz clock, damping off unless set, and a shortened backup period.
*/
`timescale 1ns/1ps
module flow_meter_output_processing_tb;
  logic CLK_SYS, RESET, SAMPLE_STB, SENSOR_ERROR, WINDOW_MODE_1, WINDOW_MODE_2;
  logic SWITCH_THRESHOLD_WE, RELEASE_THRESHOLD_WE, MANUAL_RESET, EXTERNAL_RESET_INPUT;
  logic SIM_ACTIVE, RESTORE_STB, FIRST_OUTPUT, FIRST_OUTPUT_OE, SECOND_OUTPUT;
  logic SECOND_OUTPUT_OE, BACKUP_STB, ERROR_FLAG, CONFIG_REJECT, line1, line2;
  logic [15:0] FLOW_IN, TEMP_IN, SWITCH_THRESHOLD, RELEASE_THRESHOLD, WINDOW_UPPER_LIMIT;
  logic [15:0] WINDOW_LOWER_LIMIT, ANALOG_START_POINT, ANALOG_END_POINT, LOW_FLOW_CUTOFF;
  logic [15:0] SIM_FLOW, ANALOG_CURRENT, DISPLAY_VALUE;
  logic [31:0] PULSE_QUANTITY_SETTING, COUNTER_TIME_WINDOW, RESTORE_TOTAL, RESTORE_ELAPSED;
  logic [31:0] TOTAL_VALUE, PREVIOUS_TOTAL, ELAPSED_SAMPLES, BACKUP_TOTAL, BACKUP_ELAPSED;
  logic [2:0] FIRST_OUTPUT_FUNC;
  logic [3:0] SECOND_OUTPUT_FUNC, DAMPING_TIME;
  logic [1:0] FAILURE_LEVEL_SELECT;
  int pulses, fails, cmp_count, n;
  fmop_top #(.BACKUP_CYC(100)) i_dut (.*);
  fmop_ctrl_model i_ctrl (.q1(FIRST_OUTPUT), .oe1(FIRST_OUTPUT_OE), .q2(SECOND_OUTPUT),
    .oe2(SECOND_OUTPUT_OE), .line1(line1), .line2(line2), .pulses(pulses));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge CLK_SYS);
  endtask
  // Strobes are spaced three cycles apart so pulses never merge.
  task automatic st(input logic [15:0] f, input int k);
    FLOW_IN = f;
    repeat (k)
    begin
      SAMPLE_STB = 1'b1;
      cyc(1);
      SAMPLE_STB = 1'b0;
      cyc(2);
    end
  endtask
  task automatic mrst;
    MANUAL_RESET = 1'b1;
    cyc(1);
    MANUAL_RESET = 1'b0;
    cyc(2);
  endtask
  task automatic wr_thr(input logic s, input logic [15:0] v);
    SWITCH_THRESHOLD = v;
    RELEASE_THRESHOLD = v;
    SWITCH_THRESHOLD_WE = s;
    RELEASE_THRESHOLD_WE = !s;
    cyc(1);
    {SWITCH_THRESHOLD_WE, RELEASE_THRESHOLD_WE} = 2'h0;
    cyc(1);
  endtask
  task automatic wait_bk(output int k);
    k = 0;
    while (BACKUP_STB !== 1'b1)
    begin
      cyc(1);
      k++;
      if (k > 250)
      begin
        fails++;
        summarize();
      end
    end
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_total;
    st(16'h03e8, 2);
    mrst();
    st(16'h03e8, 3);
    mrst();
    chk(TOTAL_VALUE, 32'h0);
    chk(PREVIOUS_TOTAL, 32'h0bb8);
    LOW_FLOW_CUTOFF = 16'h01f4;
    st(16'h0190, 2);
    mrst();
    st(16'h0190, 3);
    chk(TOTAL_VALUE, 32'h0);
    DAMPING_TIME = 4'h1;
    st(16'h03e8, 1);
    chk(DISPLAY_VALUE, 16'h01f4);
    st(16'h03e8, 1);
    chk(DISPLAY_VALUE, 16'h02ee);
    {DAMPING_TIME, LOW_FLOW_CUTOFF} = 20'h0;
    RESTORE_TOTAL = 32'h3039;
    RESTORE_STB = 1'b1;
    cyc(1);
    RESTORE_STB = 1'b0;
    cyc(2);
    chk(TOTAL_VALUE, 32'h3039);
    wait_bk(n);
    chk(BACKUP_TOTAL, 32'h3039);
    cyc(1);
    wait_bk(n);
    chk(n + 1, 32'd100);
  endtask
  task automatic t_sim;
    SIM_FLOW = 16'h07d0;
    {SIM_ACTIVE, SENSOR_ERROR} = 2'h3;
    cyc(3);
    chk(TOTAL_VALUE, 32'h0);
    st(16'h1388, 3);
    chk(ERROR_FLAG, 1'b0);
    {SIM_ACTIVE, SENSOR_ERROR} = 2'h0;
    cyc(3);
    chk(TOTAL_VALUE, 32'h3039);
  endtask
  task automatic t_hyst;
    FIRST_OUTPUT_FUNC = 3'h0;
    wr_thr(1'b1, 16'h1388);
    wr_thr(1'b0, 16'h0bb8);
    st(16'h1770, 3);
    chk(line1, 1'b1);
    st(16'h0fa0, 3);
    chk(line1, 1'b1);
    st(16'h07d0, 3);
    chk(line1, 1'b0);
    wr_thr(1'b1, 16'h1b58);
    st(16'h1f40, 3);
    chk(line1, 1'b1);
    st(16'h0fa0, 3);
    chk(line1, 1'b0);
  endtask
  task automatic t_pulse;
    st(16'h03e8, 8);
    FIRST_OUTPUT_FUNC = 3'h3;
    cyc(3);
    n = pulses;
    st(16'h03e8, 10);
    chk(pulses - n, 32'h4);
    chk(CONFIG_REJECT, 1'b0);
    SECOND_OUTPUT_FUNC = 4'h8;
    cyc(3);
    chk(CONFIG_REJECT, 1'b1);
    n = pulses;
    st(16'h03e8, 10);
    chk(pulses - n, 32'h0);
  endtask
  task automatic t_analog;
    FIRST_OUTPUT_FUNC = 3'h4;
    SECOND_OUTPUT_FUNC = 4'h4;
    ANALOG_END_POINT = 16'h2710;
    st(16'h1388, 3);
    chk(ANALOG_CURRENT, 16'h2ee0);
    chk(line1, 1'b0);
    st(16'h2710, 3);
    chk(ANALOG_CURRENT, 16'h4e20);
    ANALOG_END_POINT = 16'h07cf;
    st(16'h2710, 3);
    chk({CONFIG_REJECT, ANALOG_CURRENT}, 17'h10fa0);
    ANALOG_END_POINT = 16'h07d0;
    st(16'h2710, 3);
    chk({CONFIG_REJECT, ANALOG_CURRENT}, 17'h04e20);
    ANALOG_END_POINT = 16'h2710;
    SENSOR_ERROR = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      FAILURE_LEVEL_SELECT = i[1:0];
      st(16'h1388, 3);
      chk(ANALOG_CURRENT, i == 0 ? fmop_pkg::FMOP_I_HI_ERR :
        (i == 1 ? fmop_pkg::FMOP_I_LO_ERR : 16'h2ee0));
    end
    SENSOR_ERROR = 1'b0;
  endtask
  task automatic t_preset;
    st(16'h03e8, 1);
    FIRST_OUTPUT_FUNC = 3'h2;
    mrst();
    chk(ELAPSED_SAMPLES, 32'h0);
    st(16'h03e8, 2);
    chk(line1, 1'b0);
    chk(ELAPSED_SAMPLES, 32'h2);
    st(16'h03e8, 1);
    chk(line1, 1'b1);
    st(16'h03e8, 2);
    chk(line1, 1'b1);
    mrst();
    chk(line1, 1'b0);
    COUNTER_TIME_WINDOW = 32'h00000002;
    st(16'h03e8, 2);
    st(16'h03e8, 2);
    chk(line1, 1'b0);
    chk(PREVIOUS_TOTAL, 32'h07d0);
    COUNTER_TIME_WINDOW = 32'h00000000;
    FIRST_OUTPUT_FUNC = 3'h4;
    cyc(2);
  endtask
  initial
  begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  initial
  begin
    {SAMPLE_STB, SENSOR_ERROR, WINDOW_MODE_1, WINDOW_MODE_2, SWITCH_THRESHOLD_WE} = 5'h0;
    {RELEASE_THRESHOLD_WE, MANUAL_RESET, EXTERNAL_RESET_INPUT, SIM_ACTIVE, RESTORE_STB} = 5'h0;
    {FLOW_IN, TEMP_IN, SWITCH_THRESHOLD, RELEASE_THRESHOLD, WINDOW_UPPER_LIMIT} = 80'h0;
    {WINDOW_LOWER_LIMIT, ANALOG_START_POINT, ANALOG_END_POINT, LOW_FLOW_CUTOFF} =
      64'h0000000027100000;
    {SIM_FLOW, COUNTER_TIME_WINDOW, RESTORE_TOTAL, RESTORE_ELAPSED, DAMPING_TIME} = 116'h0;
    FIRST_OUTPUT_FUNC = 3'h4;
    SECOND_OUTPUT_FUNC = 4'h7;
    FAILURE_LEVEL_SELECT = 2'h2;
    PULSE_QUANTITY_SETTING = 32'h09c4;
    {fails, cmp_count} = 64'h0;
    RESET = 1'b1;
    cyc(6);
    RESET = 1'b0;
    cyc(1);
    chk({FIRST_OUTPUT_OE, SECOND_OUTPUT_OE, ERROR_FLAG, TOTAL_VALUE}, 35'h0);
    t_total();
    t_sim();
    t_hyst();
    t_pulse();
    t_analog();
    t_preset();
    summarize();
  end
endmodule
